// >>> pcrs_pkg.sv
// Constants, types and register map of the program counter and return stack.
// Assumes a single 25 MHz core clock and an APB master on that clock.
package pcrs_pkg;

  localparam int PC_W     = 21;
  localparam int PTR_W    = 5;
  localparam int DEPTH    = 31;
  localparam int WORD_W   = 16;
  localparam int ADDR_W   = 8;

  // Program memory actually present, in bytes.
  localparam logic [PC_W-1:0] IMPL_BYTES = 21'h0_4000;

  // Reset and interrupt vectors, and the counter step.
  localparam logic [PC_W-1:0] VEC_RESET = 21'h0_0000;
  localparam logic [PC_W-1:0] VEC_HIGH  = 21'h0_0008;
  localparam logic [PC_W-1:0] VEC_LOW   = 21'h0_0018;
  localparam logic [PC_W-1:0] PC_STEP   = 21'h0_0002;

  localparam logic [PTR_W-1:0] PTR_EMPTY = 5'h00;
  localparam logic [PTR_W-1:0] PTR_FULL  = 5'h1f;
  localparam logic [PTR_W-1:0] PTR_ONE   = 5'h01;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_LOW_BYTE  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_HIGH_LAT  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TOP_LAT   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STACK_PTR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_TOS_UPPER = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TOS_HIGH  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TOS_LOW   = 8'h18;

  // Field positions in the stack pointer register.
  localparam int BIT_FULL = 7;
  localparam int BIT_UNF  = 6;

  // Commands from the instruction execution logic.
  typedef enum logic [7:0] {
    PCRS_OP_NONE = 8'h01,
    PCRS_OP_ADV  = 8'h02,
    PCRS_OP_JUMP = 8'h04,
    PCRS_OP_CALL = 8'h08,
    PCRS_OP_RET  = 8'h10,
    PCRS_OP_IRQ  = 8'h20,
    PCRS_OP_PUSH = 8'h40,
    PCRS_OP_POP  = 8'h80
  } pcrs_op_t;

  // One command with its operands.
  typedef struct packed {
    pcrs_op_t         op;
    logic [PC_W-1:0]  target;
    logic             irq_high;
  } pcrs_cmd_t;

endpackage

// >>> pcrs_core.sv
// Program counter, latch registers and 31-level return stack with APB access.
// Assumes commands, enables and memory data arrive on ref_clk already.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module pcrs_core (
  input  wire logic                         ref_clk,
  input  wire logic                         rstn,
  input  wire logic                         core_reset,
  input  wire pcrs_pkg::pcrs_cmd_t          cmd,
  input  wire logic                         global_irq_enable_high,
  input  wire logic                         global_irq_enable_low,
  input  wire logic                         overflow_reset_enable,
  input  wire logic [pcrs_pkg::WORD_W-1:0]  mem_rdata,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic      [pcrs_pkg::PC_W-1:0]    pc,
  output logic      [pcrs_pkg::WORD_W-1:0]  fetch_word,
  output logic                              stack_reset_pulse
);

  localparam int PC_W  = pcrs_pkg::PC_W;
  localparam int PTR_W = pcrs_pkg::PTR_W;

  // Stack storage; index zero has no word behind it.
  logic [PC_W-1:0]  stack_mem [1:pcrs_pkg::DEPTH];
  logic [PTR_W-1:0] ptr;
  logic             stack_full_flag;
  logic             stack_underflow_flag;
  logic [7:0]       counter_high_latch;
  logic [4:0]       counter_top_latch;

  logic [PC_W-1:0]  next_pc;
  logic [PTR_W-1:0] next_ptr;
  logic             set_full;
  logic             set_unf;
  logic             mem_we;
  logic [PTR_W-1:0] mem_wa;
  logic [PC_W-1:0]  mem_wd;
  logic             stk_rst;
  logic [PC_W-1:0]  stack_top;
  logic [PC_W-1:0]  pc_plus;
  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;
  logic [PC_W-1:0]  push_val;
  logic             do_push;
  logic             do_pop;
  logic             pop_load;

  logic             apb_fire;
  logic             apb_wr;
  logic             apb_rd;
  logic [7:0]       ofs;
  logic             hit_low;
  logic             hit_hlat;
  logic             hit_tlat;
  logic             hit_sp;
  logic             hit_tu;
  logic             hit_th;
  logic             hit_tl;
  logic             mapped;
  logic [31:0]      rd_mux;
  logic             clr_full;
  logic             clr_unf;
  logic             irq_ok;

  // Bus decode; a transfer completes at the edge where pready is high.
  assign apb_fire = psel & penable & pready;
  assign apb_wr   = apb_fire & pwrite;
  assign apb_rd   = apb_fire & ~pwrite;
  assign ofs      = paddr[7:0];
  assign hit_low  = (paddr[31:8] == 24'h00_0000) &&
                    (ofs == pcrs_pkg::OFS_LOW_BYTE);
  assign hit_hlat = (paddr[31:8] == 24'h00_0000) &&
                    (ofs == pcrs_pkg::OFS_HIGH_LAT);
  assign hit_tlat = (paddr[31:8] == 24'h00_0000) &&
                    (ofs == pcrs_pkg::OFS_TOP_LAT);
  assign hit_sp   = (paddr[31:8] == 24'h00_0000) &&
                    (ofs == pcrs_pkg::OFS_STACK_PTR);
  assign hit_tu   = (paddr[31:8] == 24'h00_0000) &&
                    (ofs == pcrs_pkg::OFS_TOS_UPPER);
  assign hit_th   = (paddr[31:8] == 24'h00_0000) &&
                    (ofs == pcrs_pkg::OFS_TOS_HIGH);
  assign hit_tl   = (paddr[31:8] == 24'h00_0000) &&
                    (ofs == pcrs_pkg::OFS_TOS_LOW);
  assign mapped   = hit_low | hit_hlat | hit_tlat | hit_sp |
                    hit_tu | hit_th | hit_tl;

  // Word under the pointer; an empty stack shows zero.
  assign stack_top = (ptr == pcrs_pkg::PTR_EMPTY) ? '0 : stack_mem[ptr];
  assign pc_plus   = pc + pcrs_pkg::PC_STEP;
  assign ptr_inc   = ptr + pcrs_pkg::PTR_ONE;
  assign ptr_dec   = ptr - pcrs_pkg::PTR_ONE;
  assign irq_ok    = global_irq_enable_high | global_irq_enable_low;

  // Software write-zero clears a flag; bits written as one are ignored.
  assign clr_full = apb_wr & hit_sp & ~pwdata[pcrs_pkg::BIT_FULL];
  assign clr_unf  = apb_wr & hit_sp & ~pwdata[pcrs_pkg::BIT_UNF];

  // Choose what the command pushes or pops.
  always_comb begin
    do_push  = 1'b0;
    do_pop   = 1'b0;
    pop_load = 1'b0;
    push_val = pc_plus;
    case (cmd.op)
      pcrs_pkg::PCRS_OP_CALL: begin
        do_push = 1'b1;
      end
      pcrs_pkg::PCRS_OP_IRQ: begin
        do_push  = irq_ok;
        push_val = pc;
      end
      pcrs_pkg::PCRS_OP_PUSH: begin
        do_push = 1'b1;
      end
      pcrs_pkg::PCRS_OP_RET: begin
        do_pop   = 1'b1;
        pop_load = 1'b1;
      end
      pcrs_pkg::PCRS_OP_POP: begin
        do_pop = 1'b1;
      end
      default: begin
        do_push = 1'b0;
      end
    endcase
  end

  // Next counter, pointer and stack write; bus writes to the low byte, stack pointer or top-of-stack take priority.
  always_comb begin
    next_pc  = pc;
    next_ptr = ptr;
    set_full = 1'b0;
    set_unf  = 1'b0;
    mem_we   = 1'b0;
    mem_wa   = ptr;
    mem_wd   = stack_top;
    stk_rst  = 1'b0;
    if (apb_wr && hit_low) begin
      next_pc = {counter_top_latch, counter_high_latch,
                 pwdata[7:1], 1'b0};
    end else if (apb_wr && hit_sp) begin
      next_ptr = pwdata[PTR_W-1:0];
    end else if (apb_wr && (hit_tu || hit_th || hit_tl)) begin
      // Top-of-stack bytes patch the selected word only.
      mem_we = (ptr != pcrs_pkg::PTR_EMPTY);
      if (hit_tu) begin
        mem_wd[20:16] = pwdata[4:0];
      end else if (hit_th) begin
        mem_wd[15:8] = pwdata[7:0];
      end else begin
        mem_wd[7:0] = pwdata[7:0];
      end
    end else begin
      case (cmd.op)
        pcrs_pkg::PCRS_OP_ADV: begin
          next_pc = pc_plus;
        end
        pcrs_pkg::PCRS_OP_JUMP: begin
          next_pc = {cmd.target[PC_W-1:1], 1'b0};
        end
        pcrs_pkg::PCRS_OP_CALL: begin
          next_pc = {cmd.target[PC_W-1:1], 1'b0};
        end
        pcrs_pkg::PCRS_OP_IRQ: begin
          if (irq_ok) begin
            next_pc = cmd.irq_high ? pcrs_pkg::VEC_HIGH
                                   : pcrs_pkg::VEC_LOW;
          end
        end
        pcrs_pkg::PCRS_OP_PUSH: begin
          next_pc = pc_plus;
        end
        pcrs_pkg::PCRS_OP_POP: begin
          next_pc = pc_plus;
        end
        default: begin
          next_pc = pc;
        end
      endcase
      if (do_push) begin
        if (ptr == pcrs_pkg::PTR_FULL) begin
          // Already full: the last entry is kept and the pointer stays.
          set_full = 1'b1;
        end else begin
          next_ptr = ptr_inc;
          mem_we   = 1'b1;
          mem_wa   = ptr_inc;
          mem_wd   = push_val;
          if (ptr_inc == pcrs_pkg::PTR_FULL) begin
            set_full = 1'b1;
            if (overflow_reset_enable) begin
              mem_wd   = pc_plus;
              next_ptr = pcrs_pkg::PTR_EMPTY;
              next_pc  = pcrs_pkg::VEC_RESET;
              stk_rst  = 1'b1;
            end
          end
        end
      end
      if (do_pop) begin
        if (ptr == pcrs_pkg::PTR_EMPTY) begin
          // Empty stack: a return, or any pop with overflow_reset_enable, resumes at the reset vector; pointer stays zero.
          set_unf = 1'b1;
          if (pop_load) begin
            next_pc = pcrs_pkg::VEC_RESET;
          end
          if (overflow_reset_enable) begin
            next_pc = pcrs_pkg::VEC_RESET;
            stk_rst = 1'b1;
          end
        end else begin
          if (pop_load) begin
            next_pc = {stack_top[PC_W-1:1], 1'b0};
          end
          next_ptr = ptr_dec;
        end
      end
    end
  end

  // Program counter; every reset starts at the reset vector.
  always_ff @(posedge ref_clk) begin
    if (!rstn || core_reset) begin
      pc <= pcrs_pkg::VEC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // Stack pointer is cleared by every reset.
  always_ff @(posedge ref_clk) begin
    if (!rstn || core_reset) begin
      ptr <= pcrs_pkg::PTR_EMPTY;
    end else begin
      ptr <= next_ptr;
    end
  end

  // Stack storage; written only through push or top-of-stack access.
  always_ff @(posedge ref_clk) begin
    if (mem_we && (mem_wa != pcrs_pkg::PTR_EMPTY)) begin
      stack_mem[mem_wa] <= mem_wd;
    end
  end

  // Sticky flags survive core resets; only power-on or software clears.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stack_full_flag      <= 1'b0;
      stack_underflow_flag <= 1'b0;
    end else begin
      stack_full_flag      <= set_full |
                              (stack_full_flag & ~clr_full);
      stack_underflow_flag <= set_unf |
                              (stack_underflow_flag & ~clr_unf);
    end
  end

  // Latches: loaded by software, or from the counter on a low byte read.
  always_ff @(posedge ref_clk) begin
    if (!rstn || core_reset) begin
      counter_high_latch <= 8'h00;
      counter_top_latch  <= 5'h00;
    end else if (apb_rd && hit_low) begin
      counter_high_latch <= pc[15:8];
      counter_top_latch  <= pc[20:16];
    end else if (apb_wr && hit_hlat) begin
      counter_high_latch <= pwdata[7:0];
    end else if (apb_wr && hit_tlat) begin
      counter_top_latch <= pwdata[4:0];
    end
  end

  // Instruction word; space above the implemented memory reads as zero.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fetch_word <= 16'h0000;
    end else if (pc >= pcrs_pkg::IMPL_BYTES) begin
      fetch_word <= 16'h0000;
    end else begin
      fetch_word <= mem_rdata;
    end
  end

  // One-cycle request to reset the device after a stack fault.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stack_reset_pulse <= 1'b0;
    end else begin
      stack_reset_pulse <= stk_rst;
    end
  end

  // Read data mux; the middle and upper counter bytes are not mapped.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_low) begin
      rd_mux[7:0] = pc[7:0];
    end else if (hit_hlat) begin
      rd_mux[7:0] = counter_high_latch;
    end else if (hit_tlat) begin
      rd_mux[4:0] = counter_top_latch;
    end else if (hit_sp) begin
      rd_mux[pcrs_pkg::BIT_FULL] = stack_full_flag;
      rd_mux[pcrs_pkg::BIT_UNF]  = stack_underflow_flag;
      rd_mux[PTR_W-1:0]          = ptr;
    end else if (hit_tu) begin
      rd_mux[4:0] = stack_top[20:16];
    end else if (hit_th) begin
      rd_mux[7:0] = stack_top[15:8];
    end else if (hit_tl) begin
      rd_mux[7:0] = stack_top[7:0];
    end
  end

  // APB answer: one wait state, data and error captured with pready.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

endmodule

// >>> pcrs_prog_mem.sv
// Program memory model facing the program counter and return stack.
// Assumes a combinational read at the byte address held in pc.
`timescale 1ns/100ps
module pcrs_prog_mem (
  input  wire logic [pcrs_pkg::PC_W-1:0]   pc,
  output logic      [pcrs_pkg::WORD_W-1:0] mem_rdata
);
  // Only addresses with pc[16:1] equal to 16'hc3c3 answer zero, so the zeros beyond the
  // implemented space must come from the core itself.
  assign mem_rdata = pc[16:1] ^ 16'hc3c3;
endmodule

// >>> pcrs_core_props.sv
// Checker for the program counter and return stack, bound to pcrs_core.
// Assumes only the ports of pcrs_core and the single ref_clk domain.
`timescale 1ns/100ps
module pcrs_core_props (
  input wire logic                        ref_clk,
  input wire logic                        rstn,
  input wire logic                        core_reset,
  input wire pcrs_pkg::pcrs_cmd_t         cmd,
  input wire logic                        global_irq_enable_high,
  input wire logic                        global_irq_enable_low,
  input wire logic [pcrs_pkg::WORD_W-1:0] mem_rdata,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic [pcrs_pkg::PC_W-1:0]   pc,
  input wire logic [pcrs_pkg::WORD_W-1:0] fetch_word,
  input wire logic                        stack_reset_pulse
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic live;
  logic irq_on;
  // Checks on commands apply only outside core reset and APB write completion.
  assign live   = !core_reset && !(psel && penable && pready && pwrite);
  assign irq_on = global_irq_enable_high || global_irq_enable_low;

  a_pc_word_aligned: assert property (pc[0] == 1'b0)
    else $error("pc bit zero set");
  a_step_by_two: assert property (live && cmd.op == pcrs_pkg::PCRS_OP_ADV
    |=> pc == $past(pc) + pcrs_pkg::PC_STEP) else $error("bad advance");
  // A push that overflows with the reset option goes to the reset vector.
  a_call_loads_target: assert property (live &&
    cmd.op == pcrs_pkg::PCRS_OP_CALL |=> stack_reset_pulse ||
    pc == $past(cmd.target)) else $error("call target not loaded");
  a_irq_vector_load: assert property (live && irq_on &&
    cmd.op == pcrs_pkg::PCRS_OP_IRQ |=> stack_reset_pulse || pc ==
    ($past(cmd.irq_high) ? pcrs_pkg::VEC_HIGH : pcrs_pkg::VEC_LOW))
    else $error("bad vector");
  a_stack_reset_vec: assert property (stack_reset_pulse
    |-> pc == pcrs_pkg::VEC_RESET) else $error("stack reset missed vector");
  a_irq_masked_hold: assert property (live && !irq_on &&
    cmd.op == pcrs_pkg::PCRS_OP_IRQ |=> $stable(pc))
    else $error("masked interrupt moved pc");
  a_core_reset_vector: assert property (core_reset
    |=> pc == pcrs_pkg::VEC_RESET) else $error("reset vector missed");
  a_ready_one_pulse: assert property (pready
    |-> $past(psel && penable) ##1 !pready) else $error("bad pready");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_fetch_beyond_zero: assert property (pc >= pcrs_pkg::IMPL_BYTES
    |=> fetch_word == 16'h0000) else $error("fetch beyond not zero");
  a_fetch_passes_word: assert property (pc < pcrs_pkg::IMPL_BYTES
    |=> fetch_word == $past(mem_rdata)) else $error("fetch word lost");

  // Main scenarios reached.
  c_call: cover property (live && cmd.op == pcrs_pkg::PCRS_OP_CALL);
  c_irq: cover property (live && irq_on && cmd.op == pcrs_pkg::PCRS_OP_IRQ);
  c_slverr: cover property (pslverr);
  c_stack_reset: cover property (stack_reset_pulse);
endmodule

bind pcrs_core pcrs_core_props u_props (.ref_clk, .rstn, .core_reset, .cmd,
  .global_irq_enable_high, .global_irq_enable_low, .mem_rdata, .psel,
  .penable, .pwrite, .pready, .pslverr, .pc, .fetch_word,
  .stack_reset_pulse);

// >>> program_counter_return_stack_tb.sv
// Self-checking testbench for the program counter and return stack.
// Assumes pcrs_core, pcrs_prog_mem and the bound checker are compiled.
`timescale 1ns/100ps
module program_counter_return_stack_tb;
  logic                ref_clk = 1'b0;
  logic                rstn, core_reset, psel, penable, pwrite, last_err;
  logic                global_irq_enable_high, global_irq_enable_low;
  logic                overflow_reset_enable, stack_reset_pulse;
  logic                pready, pslverr;
  logic [31:0]         paddr, pwdata, prdata;
  logic [20:0]         pc;
  logic [15:0]         mem_rdata, fetch_word;
  pcrs_pkg::pcrs_cmd_t cmd;
  int                  fail_count, cmp_count, cyc, pulses;

  pcrs_core DUT (.ref_clk, .rstn, .core_reset, .cmd, .global_irq_enable_high,
    .global_irq_enable_low, .overflow_reset_enable, .mem_rdata, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pc,
    .fetch_word, .stack_reset_pulse);
  pcrs_prog_mem u_mem (.pc, .mem_rdata);

  // Clock, reset pulse counter and the hang limit.
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (stack_reset_pulse === 1'b1) pulses++;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop;
    end
  end

  task report_and_stop;
    $display("Compared %0d, mismatched %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Issues one command for one cycle, then idles.
  task op(input pcrs_pkg::pcrs_op_t o, input logic [20:0] t, input logic h);
    @(posedge ref_clk);
    cmd <= '{o, t, h};
    @(posedge ref_clk);
    cmd <= '{pcrs_pkg::PCRS_OP_NONE, 21'h0_0000, 1'b0};
    #1;
  endtask

  // One APB transfer, held until pready is seen high at an edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {24'h00_0000, a};
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready.
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task t_reset_state;
    chk({11'h000, pc}, 32'h0000_0000);
    rd(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0000);
    rd(8'h1c, 32'h0000_0000);
    chk({31'h0000_0000, last_err}, 32'h0000_0001);
  endtask

  task t_advance;
    op(pcrs_pkg::PCRS_OP_ADV, 21'h0_0000, 1'b0);
    op(pcrs_pkg::PCRS_OP_ADV, 21'h0_0000, 1'b0);
    chk({11'h000, pc}, 32'h0000_0004);
    @(posedge ref_clk);
    #1;
    chk({16'h0000, fetch_word}, 32'h0000_c3c1);
  endtask

  task t_latches;
    wr(pcrs_pkg::OFS_HIGH_LAT, 32'h0000_0012);
    wr(pcrs_pkg::OFS_TOP_LAT, 32'h0000_0003);
    wr(pcrs_pkg::OFS_LOW_BYTE, 32'h0000_0055);
    chk({11'h000, pc}, 32'h0003_1254);
    wr(pcrs_pkg::OFS_HIGH_LAT, 32'h0000_0000);
    wr(pcrs_pkg::OFS_TOP_LAT, 32'h0000_0000);
    rd(pcrs_pkg::OFS_LOW_BYTE, 32'h0000_0054);
    rd(pcrs_pkg::OFS_HIGH_LAT, 32'h0000_0012);
    rd(pcrs_pkg::OFS_TOP_LAT, 32'h0000_0003);
  endtask

  task t_call_ret;
    op(pcrs_pkg::PCRS_OP_CALL, 21'h0_0400, 1'b0);
    chk({11'h000, pc}, 32'h0000_0400);
    rd(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0001);
    rd(pcrs_pkg::OFS_TOS_UPPER, 32'h0000_0003);
    rd(pcrs_pkg::OFS_TOS_HIGH, 32'h0000_0012);
    rd(pcrs_pkg::OFS_TOS_LOW, 32'h0000_0056);
    rd(pcrs_pkg::OFS_HIGH_LAT, 32'h0000_0012);
    wr(pcrs_pkg::OFS_TOS_LOW, 32'h0000_0080);
    op(pcrs_pkg::PCRS_OP_RET, 21'h0_0000, 1'b0);
    chk({11'h000, pc}, 32'h0003_1280);
    rd(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0000);
    rd(pcrs_pkg::OFS_HIGH_LAT, 32'h0000_0012);
    op(pcrs_pkg::PCRS_OP_RET, 21'h0_0000, 1'b0);
    chk({11'h000, pc}, 32'h0000_0000);
    rd(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0040);
    wr(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0000);
    rd(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0000);
  endtask

  // Enables go low again before every stack register access.
  task t_irq;
    op(pcrs_pkg::PCRS_OP_IRQ, 21'h0_0000, 1'b1);
    chk({11'h000, pc}, 32'h0000_0000);
    global_irq_enable_high <= 1'b1;
    op(pcrs_pkg::PCRS_OP_IRQ, 21'h0_0000, 1'b1);
    chk({11'h000, pc}, 32'h0000_0008);
    global_irq_enable_high <= 1'b0;
    global_irq_enable_low  <= 1'b1;
    op(pcrs_pkg::PCRS_OP_IRQ, 21'h0_0000, 1'b0);
    chk({11'h000, pc}, 32'h0000_0018);
    global_irq_enable_low  <= 1'b0;
    rd(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0002);
    rd(pcrs_pkg::OFS_TOS_LOW, 32'h0000_0008);
    wr(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0000);
  endtask

  // Jump drops bit zero; push and pop move the pointer and step the counter.
  task t_push_pop;
    op(pcrs_pkg::PCRS_OP_JUMP, 21'h0_0101, 1'b0);
    chk({11'h000, pc}, 32'h0000_0100);
    op(pcrs_pkg::PCRS_OP_PUSH, 21'h0_0000, 1'b0);
    chk({11'h000, pc}, 32'h0000_0102);
    rd(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0001);
    rd(pcrs_pkg::OFS_TOS_HIGH, 32'h0000_0001);
    rd(pcrs_pkg::OFS_TOS_LOW, 32'h0000_0002);
    op(pcrs_pkg::PCRS_OP_POP, 21'h0_0000, 1'b0);
    chk({11'h000, pc}, 32'h0000_0104);
    rd(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0000);
    op(pcrs_pkg::PCRS_OP_POP, 21'h0_0000, 1'b0);
    rd(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0040);
    wr(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0000);
  endtask

  task t_overflow;
    for (int i = 1; i <= 32; i++) op(pcrs_pkg::PCRS_OP_CALL, 21'(i * 4), 1'b0);
    rd(pcrs_pkg::OFS_STACK_PTR, 32'h0000_009f);
    rd(pcrs_pkg::OFS_TOS_LOW, 32'h0000_007a);
    core_reset <= 1'b1;
    @(posedge ref_clk);
    core_reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({11'h000, pc}, 32'h0000_0000);
    rd(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0080);
    overflow_reset_enable <= 1'b1;
    wr(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0000);
    for (int i = 1; i <= 31; i++) op(pcrs_pkg::PCRS_OP_CALL, 21'(i * 4), 1'b0);
    repeat (3) @(posedge ref_clk);
    #1;
    chk({11'h000, pc}, 32'h0000_0000);
    chk(pulses, 32'h0000_0001);
    rd(pcrs_pkg::OFS_STACK_PTR, 32'h0000_0080);
  endtask

  // Time-zero values, reset, then the scenarios in order.
  initial begin
    {rstn, core_reset, psel, penable, pwrite} = 5'h00;
    {global_irq_enable_high, global_irq_enable_low} = 2'h0;
    overflow_reset_enable = 1'b0;
    cmd = '{pcrs_pkg::PCRS_OP_NONE, 21'h0_0000, 1'b0};
    {paddr, pwdata} = 64'h0000_0000_0000_0000;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_reset_state;
    t_advance;
    t_latches;
    t_call_ret;
    t_irq;
    t_push_pop;
    t_overflow;
    report_and_stop;
  end
endmodule
